/* File: logic/amo_exec_unit.sv */
// Accumulator execution unit: jump, add-constant, indexed parameter,
// swap, immediate halt, system word and direct memory stores.
// Assumes one instruction per opValid pulse with its own word address.
`include "amo_defs.svh"
`default_nettype none
module amo_exec_unit #(
  parameter int TICK_CYCLES = `AMO_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Instruction issue
  input wire logic opValid,
  input wire amo_pkg::amo_op_e opCode,
  input wire amo_pkg::amo_word_t opOperand,
  input wire logic byteForm,
  input wire amo_pkg::amo_word_t pcIn,
  input wire logic logicResultBit,
  output logic opReady,
  // Operator and programming unit
  input wire logic modeSelectorRun,
  input wire logic remoteRunCommand,
  input wire logic cycleStart,
  // Program flow
  output logic jumpValid,
  output amo_pkg::amo_word_t jumpTarget,
  output logic paramSelValid,
  output amo_pkg::amo_word_t paramIndex,
  output logic stopMode,
  // Accumulators
  output amo_pkg::amo_word_t primaryAccumulator,
  output amo_pkg::amo_word_t secondaryAccumulator,
  // Memory and system data writes
  output logic memWrite,
  output amo_pkg::amo_word_t memAddr,
  output amo_pkg::amo_word_t memData,
  output logic sysWordWrite,
  output amo_pkg::amo_word_t sysWordAddr,
  output logic blockCopyStart,
  output logic [7:0] blockCopyLen,
  output amo_pkg::amo_word_t cycleLimitWord,
  output logic cycleOverrun
);
  import amo_pkg::*;

  amo_run_e runState_reg; // Run or STOP
  logic opFire; // Instruction taken this cycle
  logic resumeReq; // Either restart source
  logic indexArmed_reg; // Next instruction uses a formal parameter
  amo_word_t indexValue_reg; // Parameter position captured from accu
  amo_word_t addImm; // Sign-extended add immediate
  logic overrunRaw; // Monitor flag before output register

  assign opFire = opValid && (runState_reg == AMO_RUN);
  assign resumeReq = modeSelectorRun || remoteRunCommand;
  // Byte form holds -128..+127, word form -32768..+32767
  assign addImm = byteForm ? {{8{opOperand[7]}}, opOperand[7:0]} : opOperand;

  // ==========================================================
  // Run state: halt acts at once, only the mode selector or a remote run command restarts
  always_ff @(posedge mclk)
  begin
    if (srst)
      runState_reg <= AMO_RUN;
    else
    begin
      case (runState_reg)
        AMO_RUN:
          // Halt is unconditional; the result bit is never looked at
          if (opFire && opCode == AMO_OP_HALT)
            runState_reg <= AMO_STOP;
        AMO_STOP:
          // No instruction can leave STOP, only the outside party
          if (resumeReq)
            runState_reg <= AMO_RUN;
        default:
          runState_reg <= AMO_STOP;
      endcase
    end
  end

  // ==========================================================
  // Mode outputs registered straight from next state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stopMode <= 1'b0;
      opReady <= 1'b1;
    end
    else if (runState_reg == AMO_RUN && opFire && opCode == AMO_OP_HALT)
    begin
      stopMode <= 1'b1;
      opReady <= 1'b0;
    end
    else if (runState_reg == AMO_STOP && resumeReq)
    begin
      stopMode <= 1'b0;
      opReady <= 1'b1;
    end
  end

  // ==========================================================
  // Accumulators; the unit keeps no flags, so none can change here
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      primaryAccumulator <= `AMO_ACC_RESET;
      secondaryAccumulator <= `AMO_ACC_RESET;
    end
    else if (opFire)
    begin
      case (opCode)
        AMO_OP_LOAD:
        begin
          // Load pushes the old primary into the secondary
          secondaryAccumulator <= primaryAccumulator;
          primaryAccumulator <= opOperand;
        end
        AMO_OP_ADD:
          // 16-bit wrap; carry is discarded, secondary untouched
          primaryAccumulator <= primaryAccumulator + addImm;
        AMO_OP_SWAP:
        begin
          primaryAccumulator <= secondaryAccumulator;
          secondaryAccumulator <= primaryAccumulator;
        end
        default:
          ;
      endcase
    end
  end

  // ==========================================================
  // Relative jump: taken always, target wraps with no correction
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      jumpValid <= 1'b0;
      jumpTarget <= 16'h0000;
    end
    else
    begin
      jumpValid <= opFire && opCode == AMO_OP_JUMP;
      if (opFire && opCode == AMO_OP_JUMP)
        // Word units from the jump itself; 2 skips one instruction
        jumpTarget <= pcIn + opOperand;
    end
  end

  // ==========================================================
  // Indexed parameter: arm on the index op, apply to the next one
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      indexArmed_reg <= 1'b0;
      indexValue_reg <= 16'h0000;
      paramSelValid <= 1'b0;
      paramIndex <= 16'h0000;
    end
    else
    begin
      paramSelValid <= 1'b0;
      if (opFire && opCode == AMO_OP_INDEX)
      begin
        indexArmed_reg <= 1'b1;
        indexValue_reg <= primaryAccumulator;
        paramIndex <= primaryAccumulator;
      end
      else if (opFire && indexArmed_reg)
      begin
        // The following instruction takes the captured position
        indexArmed_reg <= 1'b0;
        paramSelValid <= 1'b1;
        paramIndex <= indexValue_reg;
      end
    end
  end

  // ==========================================================
  // Stores go straight out; no area check, so misuse can corrupt
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      memWrite <= 1'b0;
      memAddr <= 16'h0000;
      memData <= 16'h0000;
      sysWordWrite <= 1'b0;
      sysWordAddr <= 16'h0000;
      blockCopyStart <= 1'b0;
      blockCopyLen <= 8'h00;
    end
    else
    begin
      memWrite <= opFire && opCode == AMO_OP_INDSTORE;
      sysWordWrite <= opFire && opCode == AMO_OP_SYSSTORE;
      blockCopyStart <= opFire && opCode == AMO_OP_BLKCOPY;
      if (opFire && opCode == AMO_OP_INDSTORE)
      begin
        memAddr <= primaryAccumulator;
        memData <= secondaryAccumulator;
      end
      else if (opFire && opCode == AMO_OP_BLKCOPY)
      begin
        // Destination top in primary, source top in secondary
        memAddr <= primaryAccumulator;
        memData <= secondaryAccumulator;
        blockCopyLen <= opOperand[7:0];
      end
      else if (opFire && opCode == AMO_OP_SYSSTORE)
      begin
        sysWordAddr <= opOperand;
        memData <= primaryAccumulator;
      end
    end
  end

  // ==========================================================
  // Local copy of the cycle limit word feeding the monitor
  always_ff @(posedge mclk)
  begin
    if (srst)
      cycleLimitWord <= `AMO_LIMIT_RESET;
    else if (opFire && opCode == AMO_OP_SYSSTORE
      && opOperand == `AMO_SYSWORD_CYCLE_LIMIT)
      cycleLimitWord <= primaryAccumulator;
  end

  amo_cycle_monitor #(
    .TICK_CYCLES(TICK_CYCLES)
  ) cycleMon (
    .mclk(mclk),
    .srst(srst),
    .cycleStart(cycleStart),
    .limitWord(cycleLimitWord),
    .cycleOverrun(overrunRaw)
  );

  // Registered so the port comes from a flop in this module
  always_ff @(posedge mclk)
  begin
    if (srst)
      cycleOverrun <= 1'b0;
    else
      cycleOverrun <= overrunRaw;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_halt;
    opFire && opCode == AMO_OP_HALT;
  endsequence
  sequence s_stopped_quiet;
    stopMode && !opReady && !resumeReq;
  endsequence
  // The instruction taken right after an index op, itself not an index op
  sequence s_index_follow;
    opFire && indexArmed_reg && opCode != AMO_OP_INDEX;
  endsequence

  a_jump_target: assert property ((opFire && opCode == AMO_OP_JUMP)
    |=> jumpValid && jumpTarget == $past(pcIn) + $past(opOperand))
    else $error("jump target wrong");
  a_jump_any_bit: assert property ((opFire && opCode == AMO_OP_JUMP && !logicResultBit)
    |=> jumpValid)
    else $error("jump skipped on clear result bit");
  a_jump_only: assert property (jumpValid |-> $past(opFire && opCode == AMO_OP_JUMP))
    else $error("spurious jump");
  a_add_sum: assert property ((opFire && opCode == AMO_OP_ADD)
    |=> primaryAccumulator == 16'($past(primaryAccumulator) + $past(addImm)))
    else $error("add result wrong");
  a_add_no_carry: assert property ((opFire && opCode == AMO_OP_ADD)
    |=> $stable(secondaryAccumulator))
    else $error("add touched secondary accumulator");
  a_swap_pair: assert property ((opFire && opCode == AMO_OP_SWAP)
    |=> primaryAccumulator == $past(secondaryAccumulator)
    && secondaryAccumulator == $past(primaryAccumulator))
    else $error("swap wrong");
  a_halt_stop: assert property (s_halt ##1 !resumeReq |-> stopMode && !opReady)
    else $error("halt did not stop");
  a_stop_holds: assert property (s_stopped_quiet |=> stopMode)
    else $error("left STOP without operator");
  a_stop_blocks: assert property (stopMode && !resumeReq |=> !jumpValid && !memWrite)
    else $error("instruction executed in STOP");
  a_index_next: assert property (s_index_follow
    |=> paramSelValid && paramIndex == $past(indexValue_reg))
    else $error("indexed parameter not applied");
  a_limit_store: assert property ((opFire && opCode == AMO_OP_SYSSTORE
    && opOperand == `AMO_SYSWORD_CYCLE_LIMIT) |=> cycleLimitWord == $past(primaryAccumulator))
    else $error("cycle limit not stored");
  a_store_direct: assert property ((opFire && opCode == AMO_OP_INDSTORE)
    |=> memWrite && memAddr == $past(primaryAccumulator))
    else $error("indirect store not issued");
endmodule // amo_exec_unit
`default_nettype wire

/* File: inc/amo_defs.svh */
// Constants for the accumulator execution unit: offsets, reset values, timing.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
//
// Contract
// - Both accumulators are 16-bit registers
// - Relative jump resumes at signed distance
// - Relative jump ignores logic result bit
// - Distance counted in words from jump
// - Add signed byte or word immediate
// - Add ignores and keeps result bit, flags
// - Add wraps; secondary accumulator unchanged
// - Indexed op selects parameter by accumulator
// - Swap exchanges accumulators, keeps bit, flags
// - Immediate halt enters STOP at once
// - STOP held until selector or remote run
// - System word 96 is limit times 10ms
// - Stores write memory without protection gating
`ifndef AMO_DEFS_SVH
`define AMO_DEFS_SVH

// ==========================================================
// Widths
`define AMO_WORD_W 16
`define AMO_OPC_W 4

// ==========================================================
// System data word that holds the scan cycle limit
`define AMO_SYSWORD_CYCLE_LIMIT 16'h0060
`define AMO_ACC_RESET 16'h0000
`define AMO_LIMIT_RESET 16'h0000

// ==========================================================
// Timing: one limit unit is 10 ms
`define AMO_LIMIT_UNIT_MS 10
`define AMO_CLK_MHZ 200
`define AMO_TICK_CYCLES (`AMO_LIMIT_UNIT_MS * 1000 * `AMO_CLK_MHZ)

`endif

/* File: inc/amo_pkg.sv */
// Types shared by the accumulator execution unit and its cycle monitor.
// Assumes the defs header is on the include path.
`default_nettype none
package amo_pkg;
  // Operation codes presented on the instruction port
  typedef enum logic [3:0] {
    AMO_OP_NOP = 4'h0,
    AMO_OP_LOAD = 4'h1,
    AMO_OP_JUMP = 4'h2,
    AMO_OP_ADD = 4'h3,
    AMO_OP_INDEX = 4'h4,
    AMO_OP_SWAP = 4'h5,
    AMO_OP_HALT = 4'h6,
    AMO_OP_SYSSTORE = 4'h7,
    AMO_OP_INDSTORE = 4'h8,
    AMO_OP_BLKCOPY = 4'h9
  } amo_op_e;
  // Run state, one-hot
  typedef enum logic [1:0] {
    AMO_RUN = 2'b01,
    AMO_STOP = 2'b10
  } amo_run_e;
  typedef logic [15:0] amo_word_t;
endpackage
`default_nettype wire

/* File: logic/amo_cycle_monitor.sv */
// Scan cycle time monitor: counts 10 ms ticks since the last cycle start.
// Assumes cycleStart is a one-cycle pulse from the control unit.
`include "amo_defs.svh"
`default_nettype none
module amo_cycle_monitor #(
  parameter int TICK_CYCLES = `AMO_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Cycle control
  input wire logic cycleStart,
  input wire amo_pkg::amo_word_t limitWord,
  // Status
  output logic cycleOverrun
);
  import amo_pkg::*;

  logic [31:0] divCount_reg; // Cycles within the current 10 ms unit
  logic tickPulse_reg; // One-cycle enable every 10 ms
  amo_word_t unitCount_reg; // Elapsed 10 ms units

  // ==========================================================
  // 10 ms divider; restarted with each cycle so units align to it
  always_ff @(posedge mclk)
  begin
    if (srst || cycleStart)
    begin
      divCount_reg <= 32'h0;
      tickPulse_reg <= 1'b0;
    end
    else if (divCount_reg == 32'(TICK_CYCLES - 1))
    begin
      divCount_reg <= 32'h0;
      tickPulse_reg <= 1'b1;
    end
    else
    begin
      divCount_reg <= divCount_reg + 32'h1;
      tickPulse_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Unit counter saturates so a long stall cannot wrap past the limit
  always_ff @(posedge mclk)
  begin
    if (srst || cycleStart)
      unitCount_reg <= 16'h0000;
    else if (tickPulse_reg && unitCount_reg != 16'hffff)
      unitCount_reg <= unitCount_reg + 16'h0001;
  end

  // ==========================================================
  // Overrun once elapsed units reach the limit; zero limit disables
  always_ff @(posedge mclk)
  begin
    if (srst || cycleStart)
      cycleOverrun <= 1'b0;
    else if (limitWord != 16'h0000 && unitCount_reg >= limitWord)
      cycleOverrun <= 1'b1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_limit_scale: assert property ((!cycleStart && limitWord != 16'h0000
    && unitCount_reg >= limitWord) |=> cycleOverrun || $past(cycleStart))
    else $error("overrun not raised at cycle limit");
  a_overrun_cause: assert property ($rose(cycleOverrun) |-> $past(unitCount_reg) >= $past(limitWord))
    else $error("overrun raised before limit");
endmodule // amo_cycle_monitor
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the accumulator execution unit.
// Assumes the package is compiled first and the defs header is on the include path.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import amo_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk, srst, opValid, byteForm, logicResultBit, lrb;
  logic modeSelectorRun, remoteRunCommand, cycleStart;
  amo_op_e opCode;
  amo_word_t opOperand, pcIn;
  logic opReady, jumpValid, paramSelValid, stopMode, memWrite, sysWordWrite;
  logic blockCopyStart, cycleOverrun;
  amo_word_t jumpTarget, paramIndex, primaryAccumulator, secondaryAccumulator;
  amo_word_t memAddr, memData, sysWordAddr, cycleLimitWord;
  logic [7:0] blockCopyLen;
  int badCount = 0;
  int nChecks = 0;
  // Short tick so the 10-unit limit expires within tens of cycles
  amo_exec_unit #(.TICK_CYCLES(4)) i_dut (.mclk(mclk), .srst(srst), .opValid(opValid),
    .opCode(opCode), .opOperand(opOperand), .byteForm(byteForm), .pcIn(pcIn),
    .logicResultBit(logicResultBit), .opReady(opReady), .modeSelectorRun(modeSelectorRun),
    .remoteRunCommand(remoteRunCommand), .cycleStart(cycleStart), .jumpValid(jumpValid),
    .jumpTarget(jumpTarget), .paramSelValid(paramSelValid), .paramIndex(paramIndex),
    .stopMode(stopMode), .primaryAccumulator(primaryAccumulator),
    .secondaryAccumulator(secondaryAccumulator), .memWrite(memWrite), .memAddr(memAddr),
    .memData(memData), .sysWordWrite(sysWordWrite), .sysWordAddr(sysWordAddr),
    .blockCopyStart(blockCopyStart), .blockCopyLen(blockCopyLen),
    .cycleLimitWord(cycleLimitWord), .cycleOverrun(cycleOverrun));
  // ==========================================================
  // Clock: 5 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Compare with case inequality so an unknown never matches
  task automatic check(input amo_word_t got, input amo_word_t exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One instruction; returns just after the edge that took it, when effects show
  task automatic issue(input amo_op_e c, input amo_word_t d, input logic bf,
                       input amo_word_t pc);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    opOperand <= d;
    byteForm <= bf;
    pcIn <= pc;
    logicResultBit <= lrb;
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask
  // One-cycle pulse on a side input; selector 0 remote run, 1 mode selector, 2 cycle start
  task automatic strobe(input int which);
    @(posedge mclk);
    if (which == 0) remoteRunCommand <= 1'b1;
    else if (which == 1) modeSelectorRun <= 1'b1;
    else cycleStart <= 1'b1;
    @(posedge mclk);
    remoteRunCommand <= 1'b0;
    modeSelectorRun <= 1'b0;
    cycleStart <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset;
    check(opReady, 16'h0001, "ready after reset");
    check(stopMode, 16'h0000, "stop after reset");
    check(primaryAccumulator, 16'h0000, "primary after reset");
    check(secondaryAccumulator, 16'h0000, "secondary after reset");
  endtask
  // Jumps with result bit low and high, negative extreme, wrap past the top
  task automatic test_jump;
    lrb = 1'b0;
    issue(AMO_OP_JUMP, 16'h0002, 1'b0, 16'h000a);
    check(jumpValid, 16'h0001, "jump taken");
    check(jumpTarget, 16'h000c, "skip one word");
    lrb = 1'b1;
    issue(AMO_OP_JUMP, 16'h8000, 1'b0, 16'h8010);
    check(jumpValid, 16'h0001, "jump taken with bit set");
    check(jumpTarget, 16'h0010, "most negative distance");
    issue(AMO_OP_JUMP, 16'h7fff, 1'b0, 16'hfff0);
    check(jumpTarget, 16'h7fef, "target wraps uncorrected");
    @(posedge mclk);
    #1;
    check(jumpValid, 16'h0000, "jump pulse one cycle");
  endtask
  // Byte and word immediates, byte extremes, overflow wrap
  task automatic test_add;
    issue(AMO_OP_LOAD, 16'h5555, 1'b0, 16'h0020);
    issue(AMO_OP_LOAD, 16'h1020, 1'b0, 16'h0021);
    issue(AMO_OP_ADD, 16'h00df, 1'b1, 16'h0022);
    check(primaryAccumulator, 16'h0fff, "add byte -33");
    lrb = 1'b0;
    issue(AMO_OP_ADD, 16'h0100, 1'b0, 16'h0023);
    check(primaryAccumulator, 16'h10ff, "add word 256");
    check(secondaryAccumulator, 16'h5555, "secondary kept");
    issue(AMO_OP_LOAD, 16'hffff, 1'b0, 16'h0024);
    issue(AMO_OP_ADD, 16'h0002, 1'b0, 16'h0025);
    check(primaryAccumulator, 16'h0001, "sum truncated");
    check(secondaryAccumulator, 16'h10ff, "no carry out");
    issue(AMO_OP_ADD, 16'hab7f, 1'b1, 16'h0026);
    check(primaryAccumulator, 16'h0080, "byte +127 upper bits ignored");
    issue(AMO_OP_ADD, 16'h0080, 1'b1, 16'h0027);
    check(primaryAccumulator, 16'h0000, "byte -128");
    check(opReady, 16'h0001, "still running");
  endtask
  // Two swaps back to back
  task automatic test_swap;
    lrb = 1'b1;
    issue(AMO_OP_SWAP, 16'h0000, 1'b0, 16'h0030);
    check(primaryAccumulator, 16'h10ff, "swap primary");
    check(secondaryAccumulator, 16'h0000, "swap secondary");
    issue(AMO_OP_SWAP, 16'h0000, 1'b0, 16'h0031);
    check(primaryAccumulator, 16'h0000, "swap back");
  endtask
  // Index arms, following instruction selects the parameter
  task automatic test_index;
    issue(AMO_OP_LOAD, 16'h0002, 1'b0, 16'h0040);
    issue(AMO_OP_INDEX, 16'h0000, 1'b0, 16'h0041);
    check(paramSelValid, 16'h0000, "no select at index");
    issue(AMO_OP_NOP, 16'h0000, 1'b0, 16'h0042);
    check(paramSelValid, 16'h0001, "next op indexed");
    check(paramIndex, 16'h0002, "parameter position");
    issue(AMO_OP_NOP, 16'h0000, 1'b0, 16'h0043);
    check(paramSelValid, 16'h0000, "only one op indexed");
  endtask
  // Indirect store and block copy go straight out
  task automatic test_stores;
    issue(AMO_OP_LOAD, 16'hf0a2, 1'b0, 16'h0050);
    issue(AMO_OP_LOAD, 16'hee90, 1'b0, 16'h0051);
    issue(AMO_OP_INDSTORE, 16'h0000, 1'b0, 16'h0052);
    check(memWrite, 16'h0001, "store write");
    check(memAddr, 16'hee90, "store address");
    check(memData, 16'hf0a2, "store data");
    issue(AMO_OP_BLKCOPY, 16'h000c, 1'b0, 16'h0053);
    check(blockCopyStart, 16'h0001, "copy start");
    check({8'h00, blockCopyLen}, 16'h000c, "copy length");
  endtask
  // Limit word 96 and the overrun it sets, in units of 4 cycles here
  task automatic test_sysword;
    issue(AMO_OP_LOAD, 16'h000a, 1'b0, 16'h0060);
    issue(AMO_OP_SYSSTORE, 16'h0060, 1'b0, 16'h0061);
    check(sysWordWrite, 16'h0001, "system word write");
    check(sysWordAddr, 16'h0060, "system word 96");
    check(cycleLimitWord, 16'h000a, "limit of 10 units");
    check(memData, 16'h000a, "system word data");
    // A store to another system word must leave the limit alone
    issue(AMO_OP_SWAP, 16'h0000, 1'b0, 16'h0062);
    issue(AMO_OP_SYSSTORE, 16'h0061, 1'b0, 16'h0063);
    check(sysWordAddr, 16'h0061, "other system word");
    check(memData, 16'hee90, "other system word data");
    check(cycleLimitWord, 16'h000a, "limit kept by other word");
    issue(AMO_OP_SWAP, 16'h0000, 1'b0, 16'h0064);
    check(primaryAccumulator, 16'h000a, "primary restored");
    strobe(2);
    repeat (34) @(posedge mclk);
    #1;
    check(cycleOverrun, 16'h0000, "no overrun before limit");
    repeat (12) @(posedge mclk);
    #1;
    check(cycleOverrun, 16'h0001, "overrun after limit");
    strobe(2);
    @(posedge mclk);
    #1;
    check(cycleOverrun, 16'h0000, "cleared by cycle start");
  endtask
  // Halt, refused op, restart by each of the two means
  task automatic test_halt;
    issue(AMO_OP_HALT, 16'h0000, 1'b0, 16'h0070);
    check(stopMode, 16'h0001, "stop entered");
    check(opReady, 16'h0000, "not ready in stop");
    issue(AMO_OP_ADD, 16'h0005, 1'b0, 16'h0071);
    check(primaryAccumulator, 16'h000a, "op refused in stop");
    strobe(0);
    check(stopMode, 16'h0000, "remote run resumes");
    check(opReady, 16'h0001, "ready after remote run");
    lrb = 1'b0;
    issue(AMO_OP_HALT, 16'h0000, 1'b0, 16'h0072);
    check(stopMode, 16'h0001, "stop with bit low");
    strobe(1);
    check(stopMode, 16'h0000, "selector resumes");
    issue(AMO_OP_ADD, 16'h0001, 1'b1, 16'h0073);
    check(primaryAccumulator, 16'h000b, "runs after restart");
  endtask
  // ==========================================================
  // Verdict: one place ends the run
  task automatic finishTest;
    $display("Checks: %0d, mismatches: %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: whole sequence needs about 120 cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    badCount++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finishTest;
  end
  // Main sequence
  initial
  begin
    srst = 1'b1;
    opValid = 1'b0;
    opCode = AMO_OP_NOP;
    opOperand = 16'h0000;
    byteForm = 1'b0;
    pcIn = 16'h0000;
    logicResultBit = 1'b0;
    lrb = 1'b0;
    modeSelectorRun = 1'b0;
    remoteRunCommand = 1'b0;
    cycleStart = 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1;
    test_reset;
    test_jump;
    test_add;
    test_swap;
    test_index;
    test_stores;
    test_sysword;
    test_halt;
    finishTest;
  end
endmodule // tb_top
`default_nettype wire
